// ### include/vcdac_cfg.svh
// constants of the vcom dac setting slave: address, field positions, reset values, timing
// Contract
// - data falling while clock high is a start and opens a transaction
// - data rising while clock high is a stop and closes the transaction
// - seven-bit address plus direction bit; match on byte 9E, direction ignored
// - direction high returns the setting; direction low accepts a new setting
// - receiving party acknowledges every byte on the ninth clock pulse
// - acknowledge holds data low through the whole clock-high period
// - data byte is eight bits: seven setting bits plus one flag bit
// - read flag is 1 when eeprom programming is done, 0 while busy
// - write flag 1 updates register only; flag 0 also programs eeprom (the code drops such a request while eeprom is still busy)
// - interface works with bus clock rates up to 400 kbps
// - write-enable input low blocks eeprom programming; high allows it
// - start-up copies the stored eeprom value into the setting register
// - device is slave only; master starts transfers and makes the clock
`ifndef VCDAC_CFG_SVH
`define VCDAC_CFG_SVH

// bus address byte, direction bit masked off
`define VCDAC_ADDR_BYTE     8'h9E
`define VCDAC_ADDR_HI       7
`define VCDAC_ADDR_LO       1

// data byte layout: setting in the upper seven bits, flag in the last bit sent
`define VCDAC_DATA_W        7
`define VCDAC_SET_HI        7
`define VCDAC_SET_LO        1
`define VCDAC_FLAG_BIT      0
`define VCDAC_BITS_PER_BYTE 4'h8
`define VCDAC_LAST_TX_BIT   4'h7

// reset values
`define VCDAC_SETTING_RST   7'h00
`define VCDAC_EE_INIT       7'h40

// timing
`define VCDAC_CLK_KHZ       10000
`define VCDAC_EE_PROG_US    10000
`define VCDAC_BUS_MAX_KBPS  400
`define VCDAC_TMR_W         20

`endif

// ### include/vcdac_pkg.sv
// types of the vcom dac setting slave
`default_nettype none
`include "vcdac_cfg.svh"

package vcdac_pkg;

  typedef enum logic [3:0] {
    ST_BOOT,
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_DATA,
    ST_WR_ACK,
    ST_RD_DATA,
    ST_RD_ACK,
    ST_SKIP
  } vcdac_state_t;

  typedef struct packed {
    vcdac_state_t                  state;
    logic                          scl_q;
    logic                          sda_q;
    logic [3:0]                    cnt;
    logic [7:0]                    shreg;
    logic                          rw;
    logic                          nack;
    logic                          sda_oe_b;
    logic [`VCDAC_DATA_W-1:0]      setting;
    logic [`VCDAC_DATA_W-1:0]      ee_cell;
    logic [`VCDAC_DATA_W-1:0]      ee_wdata;
    logic                          ee_busy;
    logic [`VCDAC_TMR_W-1:0]       ee_timer;
  } vcdac_regs_t;

endpackage

`default_nettype wire

// ### src/vcdac_slave.sv
// two-wire slave holding a seven-bit dac setting with an eeprom copy
`timescale 1ns/100ps
`default_nettype none
`include "vcdac_cfg.svh"

module vcdac_slave #(
  parameter int unsigned PROG_CYCLES =
    `VCDAC_EE_PROG_US * `VCDAC_CLK_KHZ / 1000
) (
  // clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_b_i,
  // two-wire bus pins
  input  wire logic                     scl_i,
  input  wire logic                     sda_i,
  output logic                          sda_o,
  output logic                          sda_oe_b_o,
  // eeprom write enable pin
  input  wire logic                     ee_wr_en_i,
  // status and setting towards the dac
  output logic [`VCDAC_DATA_W-1:0]      dac_code_o,
  output logic                          ee_busy_o
);

  localparam logic [`VCDAC_TMR_W-1:0] TMR_LAST = `VCDAC_TMR_W'(PROG_CYCLES - 1);
  localparam logic [7:0]              ADDR_BYTE = `VCDAC_ADDR_BYTE;
  localparam logic [3:0]              BYTE_BITS = `VCDAC_BITS_PER_BYTE;
  localparam logic [3:0]              LAST_TX   = `VCDAC_LAST_TX_BIT;

  vcdac_pkg::vcdac_regs_t slv_reg;
  vcdac_pkg::vcdac_regs_t slv_next;

  // synchronised pins
  logic [2:0] pins_sync;
  logic       s_scl;
  logic       s_sda;
  logic       s_wr_en;

  // bus events
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       addr_match;
  logic [7:0] rd_byte;

  // pins come from another domain; the write-enable pin idles low like its pull-down
  vcdac_sync #(
    .WIDTH   (3),
    .RST_VAL (3'b110)
  ) u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   ({scl_i, sda_i, ee_wr_en_i}),
    .sync_o    (pins_sync)
  );

  assign s_scl   = pins_sync[2];
  assign s_sda   = pins_sync[1];
  assign s_wr_en = pins_sync[0];

  // edges judged on the synchronised copies only; at 10 MHz a 400 kbps clock
  // still leaves several samples per phase
  assign scl_rise   = s_scl & ~slv_reg.scl_q;
  assign scl_fall   = ~s_scl & slv_reg.scl_q;
  assign start_seen = s_scl & slv_reg.scl_q & slv_reg.sda_q & ~s_sda;
  assign stop_seen  = s_scl & slv_reg.scl_q & ~slv_reg.sda_q & s_sda;

  // direction bit plays no part in the match
  assign addr_match = slv_reg.shreg[`VCDAC_ADDR_HI:`VCDAC_ADDR_LO] ==
                      ADDR_BYTE[`VCDAC_ADDR_HI:`VCDAC_ADDR_LO];

  // read byte: setting high, ready flag in the last bit
  assign rd_byte = {slv_reg.setting, ~slv_reg.ee_busy};

  always_comb begin
    slv_next       = slv_reg;
    slv_next.scl_q = s_scl;
    slv_next.sda_q = s_sda;

    // eeprom program timer; cell changes only when programming ends
    if (slv_reg.ee_busy) begin
      if (slv_reg.ee_timer == TMR_LAST) begin
        slv_next.ee_busy  = 1'b0;
        slv_next.ee_timer = '0;
        slv_next.ee_cell  = slv_reg.ee_wdata;
      end else begin
        slv_next.ee_timer = slv_reg.ee_timer + 1'b1;
      end
    end

    unique case (slv_reg.state)
      vcdac_pkg::ST_BOOT: begin
        // power-up copy of the stored value
        slv_next.setting = slv_reg.ee_cell;
        slv_next.state   = vcdac_pkg::ST_IDLE;
      end

      vcdac_pkg::ST_IDLE: begin
        // nothing to do until a start; only the master clocks the bus
        slv_next.sda_oe_b = 1'b1;
      end

      vcdac_pkg::ST_ADDR: begin
        if (scl_rise) begin
          slv_next.shreg = {slv_reg.shreg[6:0], s_sda};
          slv_next.cnt   = slv_reg.cnt + 1'b1;
        end else if (scl_fall && slv_reg.cnt == BYTE_BITS) begin
          if (addr_match) begin
            // pull low now so data is steady before the ninth clock rises
            slv_next.sda_oe_b = 1'b0;
            slv_next.rw       = slv_reg.shreg[0];
            slv_next.state    = vcdac_pkg::ST_ADDR_ACK;
          end else begin
            // stay released and deaf until the next start
            slv_next.sda_oe_b = 1'b1;
            slv_next.state    = vcdac_pkg::ST_SKIP;
          end
        end
      end

      vcdac_pkg::ST_ADDR_ACK: begin
        // ack held through the whole high phase, dropped on the falling edge
        if (scl_fall) begin
          slv_next.cnt = '0;
          if (slv_reg.rw) begin
            // direction high: send the setting back
            slv_next.shreg    = rd_byte;
            slv_next.sda_oe_b = rd_byte[7];
            slv_next.state    = vcdac_pkg::ST_RD_DATA;
          end else begin
            // direction low: take a new setting
            slv_next.shreg    = '0;
            slv_next.sda_oe_b = 1'b1;
            slv_next.state    = vcdac_pkg::ST_WR_DATA;
          end
        end
      end

      vcdac_pkg::ST_WR_DATA: begin
        if (scl_rise) begin
          slv_next.shreg = {slv_reg.shreg[6:0], s_sda};
          slv_next.cnt   = slv_reg.cnt + 1'b1;
        end else if (scl_fall && slv_reg.cnt == BYTE_BITS) begin
          // every byte received is acknowledged
          slv_next.sda_oe_b = 1'b0;
          slv_next.state    = vcdac_pkg::ST_WR_ACK;
          // register always follows the byte
          slv_next.setting  = slv_reg.shreg[`VCDAC_SET_HI:`VCDAC_SET_LO];
          // flag low asks for eeprom too, only with write enable high
          // a request while still programming is dropped to keep the cell consistent
          if (!slv_reg.shreg[`VCDAC_FLAG_BIT] && s_wr_en && !slv_reg.ee_busy) begin
            slv_next.ee_wdata = slv_reg.shreg[`VCDAC_SET_HI:`VCDAC_SET_LO];
            slv_next.ee_busy  = 1'b1;
            slv_next.ee_timer = '0;
          end
        end
      end

      vcdac_pkg::ST_WR_ACK: begin
        if (scl_fall) begin
          slv_next.sda_oe_b = 1'b1;
          slv_next.cnt      = '0;
          slv_next.shreg    = '0;
          slv_next.state    = vcdac_pkg::ST_WR_DATA;
        end
      end

      vcdac_pkg::ST_RD_DATA: begin
        // next bit goes out on each falling edge, msb first
        if (scl_fall) begin
          if (slv_reg.cnt == LAST_TX) begin
            slv_next.sda_oe_b = 1'b1;
            slv_next.nack     = 1'b1;
            slv_next.state    = vcdac_pkg::ST_RD_ACK;
          end else begin
            slv_next.cnt      = slv_reg.cnt + 1'b1;
            slv_next.shreg    = {slv_reg.shreg[6:0], 1'b0};
            slv_next.sda_oe_b = slv_reg.shreg[6];
          end
        end
      end

      vcdac_pkg::ST_RD_ACK: begin
        // master is the receiver here and acknowledges
        if (scl_rise) begin
          slv_next.nack = s_sda;
        end else if (scl_fall) begin
          slv_next.cnt = '0;
          if (!slv_reg.nack) begin
            slv_next.shreg    = rd_byte;
            slv_next.sda_oe_b = rd_byte[7];
            slv_next.state    = vcdac_pkg::ST_RD_DATA;
          end else begin
            slv_next.sda_oe_b = 1'b1;
            slv_next.state    = vcdac_pkg::ST_SKIP;
          end
        end
      end

      vcdac_pkg::ST_SKIP: begin
        slv_next.sda_oe_b = 1'b1;
      end

      default: begin
        slv_next.sda_oe_b = 1'b1;
        slv_next.state    = vcdac_pkg::ST_IDLE;
      end
    endcase

    // start or stop wins over any byte in progress, also a repeated start
    if (slv_reg.state != vcdac_pkg::ST_BOOT) begin
      if (start_seen) begin
        slv_next.state    = vcdac_pkg::ST_ADDR;
        slv_next.cnt      = '0;
        slv_next.shreg    = '0;
        slv_next.sda_oe_b = 1'b1;
      end else if (stop_seen) begin
        slv_next.state    = vcdac_pkg::ST_IDLE;
        slv_next.cnt      = '0;
        slv_next.sda_oe_b = 1'b1;
      end
    end
  end

  // eeprom cell takes its factory value on reset; reset stands in for power-up
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      slv_reg          <= '0;
      slv_reg.state    <= vcdac_pkg::ST_BOOT;
      slv_reg.scl_q    <= 1'b1;
      slv_reg.sda_q    <= 1'b1;
      slv_reg.nack     <= 1'b1;
      slv_reg.sda_oe_b <= 1'b1;
      slv_reg.setting  <= `VCDAC_SETTING_RST;
      slv_reg.ee_cell  <= `VCDAC_EE_INIT;
    end else begin
      slv_reg <= slv_next;
    end
  end

  // open drain: only ever drives low
  assign sda_o      = 1'b0;
  assign sda_oe_b_o = slv_reg.sda_oe_b;
  assign dac_code_o = slv_reg.setting;
  assign ee_busy_o  = slv_reg.ee_busy;

endmodule

`default_nettype wire

// ### src/vcdac_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none

module vcdac_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_b_i,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } vcdac_sync_regs_t;

  vcdac_sync_regs_t sync_reg;
  vcdac_sync_regs_t sync_next;

  // first stage feeds only the second stage
  always_comb begin
    sync_next      = sync_reg;
    sync_next.meta = async_i;
    sync_next.sync = sync_reg.meta;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_reg <= {RST_VAL, RST_VAL};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg.sync;

endmodule

`default_nettype wire

// ### tb/test_vcdac_slave.sv
// self-checking bench for the dac setting slave
`timescale 1ns/100ps
`default_nettype none
`include "vcdac_cfg.svh"

module test_vcdac_slave;
  localparam int unsigned PROG = 2000; // short so the run stays brief
  logic                     ref_clk_i;
  logic                     rst_b_i;
  logic                     ee_wr_en_i;
  logic                     scl;
  logic                     m_sda;
  logic                     sda_o;
  logic                     sda_oe_b_o;
  logic                     ee_busy_o;
  logic [`VCDAC_DATA_W-1:0] dac_code_o;
  logic [7:0]               v0;
  logic [7:0]               v1;
  logic [1:0]               ak;
  logic                     a;
  int                       n_errors = 0;
  int                       checked = 0;
  int                       cyc = 0;
  wire logic                sda_line = (sda_oe_b_o ? 1'b1 : sda_o) & m_sda;

  vcdac_slave #(.PROG_CYCLES(PROG)) i_vcdac_slave (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_b_o(sda_oe_b_o), .ee_wr_en_i(ee_wr_en_i),
    .dac_code_o(dac_code_o), .ee_busy_o(ee_busy_o));
  vcdac_bus_master i_vcdac_bus_master (
    .ref_clk_i(ref_clk_i), .sda_i(sda_line), .scl_o(scl), .sda_o(m_sda));

  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic t_reg();
    i_vcdac_bus_master.wr(8'h9E, 8'h2B, ak);
    chk(8'(ak), 8'h00);
    chk(8'(dac_code_o), 8'h15);
    chk(8'(ee_busy_o), 8'h00);
    i_vcdac_bus_master.rd(v0, v1, a);
    chk(8'(a), 8'h00);
    chk(v0, 8'h2B);
    chk(v1, 8'h2B);
  endtask
  task automatic t_prot();
    i_vcdac_bus_master.wr(8'h9E, 8'h44, ak);
    chk(8'(dac_code_o), 8'h22);
    chk(8'(ee_busy_o), 8'h00);
    i_vcdac_bus_master.rd(v0, v1, a);
    chk(v0, 8'h45);
  endtask
  task automatic t_ee();
    ee_wr_en_i <= 1'b1;
    i_vcdac_bus_master.wr(8'h9E, 8'h54, ak);
    chk(8'(dac_code_o), 8'h2A);
    chk(8'(ee_busy_o), 8'h01);
    i_vcdac_bus_master.rd(v0, v1, a);
    chk(v0, 8'h54);
    for (int i = 0; i < 4000 && ee_busy_o; i++) @(posedge ref_clk_i);
    chk(8'(ee_busy_o), 8'h00);
    i_vcdac_bus_master.rd(v0, v1, a);
    chk(v0, 8'h55);
    ee_wr_en_i <= 1'b0;
  endtask
  task automatic t_foreign();
    logic [7:0] bad [2] = '{8'h9C, 8'h1E};
    foreach (bad[i]) begin
      i_vcdac_bus_master.wr(bad[i], 8'h00, ak);
      chk(8'(ak), 8'h03);
      chk(8'(dac_code_o), 8'h2A);
    end
  endtask
  initial begin
    rst_b_i = 1'b0;
    ee_wr_en_i = 1'b0;
    repeat (5) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    chk(8'(dac_code_o), 8'(`VCDAC_EE_INIT));
    t_reg();
    t_prot();
    t_ee();
    t_foreign();
    close_out();
  end
endmodule
`default_nettype wire

// ### tb/vcdac_bus_master.sv
// two-wire bus master model driving clock and data
`timescale 1ns/100ps
`default_nettype none

module vcdac_bus_master (
  // clock and wired data level
  input  wire logic ref_clk_i,
  input  wire logic sda_i,
  // pins, data 1 means released
  output logic      scl_o,
  output logic      sda_o
);
  localparam int Q = 7; // quarter bit: 28 cycles a bit, 357 kbps
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick();
    repeat (Q) @(posedge ref_clk_i);
  endtask
  task automatic start();
    sda_o <= 1'b1;
    tick();
    scl_o <= 1'b1;
    tick();
    sda_o <= 1'b0;
    tick();
    scl_o <= 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    tick();
    scl_o <= 1'b1;
    tick();
    sda_o <= 1'b1;
    tick();
  endtask
  // data moves only mid-low so no false start or stop is seen
  task automatic bit_x(input logic b, output logic r);
    sda_o <= b;
    tick();
    scl_o <= 1'b1;
    tick();
    r = sda_i;
    tick();
    scl_o <= 1'b0;
    tick();
  endtask
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] r,
                      output logic ao);
    for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
    bit_x(ai, ao);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] d, output logic [1:0] ak);
    logic [7:0] r;
    start();
    xfer(adr, 1'b1, r, ak[1]);
    xfer(d, 1'b1, r, ak[0]);
    stop();
    repeat (4) @(posedge ref_clk_i);
  endtask
  // two bytes read: first acked, second refused
  task automatic rd(output logic [7:0] r0, output logic [7:0] r1, output logic ak);
    logic x;
    start();
    xfer(8'h9F, 1'b1, r1, ak);
    xfer(8'hFF, 1'b0, r0, x);
    xfer(8'hFF, 1'b1, r1, x);
    stop();
    repeat (4) @(posedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// ### tb/vcdac_slave_assertions.sv
// assertions on the ports of the dac setting slave
`timescale 1ns/100ps
`default_nettype none
`include "vcdac_cfg.svh"

module vcdac_slave_assertions #(
  parameter int unsigned PROG_CYCLES = 100000
) (
  // clock and reset
  input wire logic                     ref_clk_i,
  input wire logic                     rst_b_i,
  // bus pins
  input wire logic                     scl_i,
  input wire logic                     sda_i,
  input wire logic                     sda_o,
  input wire logic                     sda_oe_b_o,
  // eeprom and dac side
  input wire logic                     ee_wr_en_i,
  input wire logic [`VCDAC_DATA_W-1:0] dac_code_o,
  input wire logic                     ee_busy_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [19:0] busy_cnt;
  logic [1:0]  up_cnt;
  // up_cnt masks the boot copy, which changes the code without an ack
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_cnt <= 20'h00000;
      up_cnt   <= 2'h0;
    end else begin
      busy_cnt <= ee_busy_o ? busy_cnt + 20'h00001 : 20'h00000;
      up_cnt   <= (up_cnt == 2'h3) ? up_cnt : up_cnt + 2'h1;
    end
  end
  sequence s_stop;
    scl_i && $rose(sda_i);
  endsequence
  sequence s_held_low;
    !sda_oe_b_o [*8];
  endsequence
  a_boot_copy: assert property (up_cnt == 2'h2 |-> dac_code_o == `VCDAC_EE_INIT)
    else $error("boot copy missing");
  a_code_at_ack: assert property (up_cnt == 2'h3 && $changed(dac_code_o) |-> !sda_oe_b_o)
    else $error("code changed outside ack");
  a_busy_cause: assert property ($rose(ee_busy_o) |-> !sda_oe_b_o && $past(ee_wr_en_i, 3))
    else $error("programming started without enable");
  a_busy_length: assert property ($fell(ee_busy_o) |-> busy_cnt == PROG_CYCLES)
    else $error("programming time wrong");
  a_drive_scl_low: assert property ($changed(sda_oe_b_o) |-> !scl_i)
    else $error("data changed with clock high");
  a_ack_held: assert property ($rose(scl_i) && !sda_oe_b_o |-> s_held_low)
    else $error("low not held through clock high");
  a_stop_release: assert property (s_stop |-> sda_oe_b_o [*8])
    else $error("line driven after stop");
  a_pull_low: assert property (!sda_oe_b_o |-> !sda_o)
    else $error("enabled output not low");
endmodule

bind vcdac_slave vcdac_slave_assertions #(.PROG_CYCLES(PROG_CYCLES)) i_vcdac_slave_assertions (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_b_o(sda_oe_b_o), .ee_wr_en_i(ee_wr_en_i), .dac_code_o(dac_code_o),
  .ee_busy_o(ee_busy_o));
`default_nettype wire
